/* File: hw/cmir_map.svh */
// Register map, field positions and reset values of the core mailbox interrupt router
`ifndef CMIR_MAP_SVH
`define CMIR_MAP_SVH

// ----------------------------------------------------------------------------
// Addresses
// ----------------------------------------------------------------------------
`define CMIR_ADDR_W 8
`define CMIR_ROUTE_BASE 8'h00
`define CMIR_CAUSE_BASE 8'h10
`define CMIR_STATUS_ADDR 8'h20
`define CMIR_MASK_ADDR 8'h24
`define CMIR_CORE_SEL_LSB 2
`define CMIR_BANK_MASK 8'hF0
`define CMIR_WORD_MASK 8'h03

// ----------------------------------------------------------------------------
// Fields and resets
// ----------------------------------------------------------------------------
`define CMIR_NCORE 4
`define CMIR_NBOX 16
`define CMIR_BOX_W 32
`define CMIR_ROUTE_W 8
`define CMIR_ROUTE_RST 8'h00
`define CMIR_CAUSE_RST 32'h0000_0000
`define CMIR_BIT_BUSERR 30
`define CMIR_BIT_TIMER 11
`define CMIR_BIT_QUIET 10
`define CMIR_BIT_PERF 9
`define CMIR_BIT_GPU 8
`define CMIR_BOX_LSB 4
`define CMIR_IRQ_EV_W 4
`define CMIR_STAT_RST 4'h0

`endif

/* File: hw/cmir_pkg.sv */
// Types shared by the core mailbox interrupt router
package cmir_pkg;
	typedef logic [3:0] cmir_nib_t;
	typedef logic [7:0] cmir_route_t;
	typedef logic [31:0] cmir_word_t;
	typedef enum logic [1:0] {CMIR_RD_NONE, CMIR_RD_ROUTE, CMIR_RD_CAUSE, CMIR_RD_CTRL} cmir_rdsel_t;
endpackage

/* File: hw/cmir_core_if.sv */
// Per-core routing bundle between the top and one core slice
`timescale 1ns/100ps
`default_nettype none
interface cmir_core_if;
	import cmir_pkg::*;
	cmir_route_t route;
	cmir_nib_t box_busy;
	cmir_nib_t timer_ev;
	logic shared_ev_timer;
	logic shared_ev_perf;
	logic shared_ev_gpu;
	logic shared_ev_buserr;
	logic shared_ev_quiet;
	logic irq;
	logic fiq;
	cmir_word_t cause;
	modport top (output route, box_busy, timer_ev, shared_ev_timer, shared_ev_perf,
		shared_ev_gpu, shared_ev_buserr, shared_ev_quiet, input irq, fiq, cause);
	modport slice (input route, box_busy, timer_ev, shared_ev_timer, shared_ev_perf,
		shared_ev_gpu, shared_ev_buserr, shared_ev_quiet, output irq, fiq, cause);
endinterface
`default_nettype wire

/* File: hw/cmir_slice.sv */
// One core's mailbox steering and cause register
`timescale 1ns/100ps
`default_nettype none
`include "cmir_map.svh"
module cmir_slice
	import cmir_pkg::*;
#(
	parameter bit HAS_QUIET = 1'b0
)
(
	input wire logic sys_clk,
	input wire logic rstn,
	cmir_core_if.slice cif
);
	cmir_nib_t fast_en;
	cmir_nib_t norm_en;
	cmir_nib_t box_fast;
	cmir_nib_t box_norm;
	cmir_word_t cause_d;
	cmir_word_t cause_q;
	logic irq_q;
	logic fiq_q;

	// ------------------------------------------------------------------------
	// Steering
	// ------------------------------------------------------------------------
	assign fast_en = cif.route[7:4];
	assign norm_en = cif.route[3:0];
	assign box_fast = cif.box_busy & fast_en;
	// Fast routing wins so no event reaches both requests
	assign box_norm = cif.box_busy & norm_en & ~fast_en;

	always_comb
	begin
		cause_d = `CMIR_CAUSE_RST;
		cause_d[`CMIR_BIT_BUSERR] = cif.shared_ev_buserr;
		cause_d[`CMIR_BIT_TIMER] = cif.shared_ev_timer;
		cause_d[`CMIR_BIT_QUIET] = HAS_QUIET & cif.shared_ev_quiet;
		cause_d[`CMIR_BIT_PERF] = cif.shared_ev_perf;
		cause_d[`CMIR_BIT_GPU] = cif.shared_ev_gpu;
		cause_d[`CMIR_BOX_LSB +: 4] = box_norm;
		cause_d[3:0] = cif.timer_ev;
	end

	// Registered to keep request pins glitch free
	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
			cause_q <= `CMIR_CAUSE_RST;
		else
			cause_q <= cause_d;
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
		begin
			irq_q <= 1'b0;
			fiq_q <= 1'b0;
		end
		else
		begin
			irq_q <= |cause_d;
			fiq_q <= |box_fast;
		end
	end

	assign cif.cause = cause_q;
	assign cif.irq = irq_q;
	assign cif.fiq = fiq_q;

	chk_fast_excl_norm: assert property (@(posedge sys_clk) disable iff (!rstn)
		|(cif.box_busy & fast_en) |=> (cif.cause[7:4] & $past(fast_en)) == 4'h0)
		else $error("fast routed mailbox shows in normal cause");
	chk_fast_raises: assert property (@(posedge sys_clk) disable iff (!rstn)
		|(cif.box_busy & fast_en) |=> cif.fiq)
		else $error("fast request missing");
	chk_quiet_core0: assert property (@(posedge sys_clk) disable iff (!rstn)
		!HAS_QUIET |-> !cif.cause[`CMIR_BIT_QUIET])
		else $error("quiet bit set on other core");
	chk_cause_irq_tie: assert property (@(posedge sys_clk) disable iff (!rstn)
		cif.irq == (cif.cause != 32'h0000_0000))
		else $error("normal request disagrees with cause");
	chk_reserved_zero: assert property (@(posedge sys_clk) disable iff (!rstn)
		(cif.cause & 32'hBFFF_F000) == 32'h0000_0000)
		else $error("reserved cause bits set");
	chk_timer_cause: assert property (@(posedge sys_clk) disable iff (!rstn)
		cif.timer_ev[0] |=> cif.cause[0])
		else $error("secure timer cause missing");
	cov_fast: cover property (@(posedge sys_clk) disable iff (!rstn) cif.fiq);
	cov_norm_box: cover property (@(posedge sys_clk) disable iff (!rstn) |cif.cause[7:4]);
endmodule
`default_nettype wire

/* File: hw/cmir_top.sv */
// Top of the core mailbox interrupt router: register port, mailbox readiness and four slices
`timescale 1ns/100ps
`default_nettype none
`include "cmir_map.svh"
module cmir_top
	import cmir_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic [511:0] box_data,
	input wire logic [15:0] generic_timer_ev,
	input wire logic [3:0] local_timer_ev,
	input wire logic [3:0] perf_ev,
	input wire logic gpu_ev,
	input wire logic bus_error_ev,
	input wire logic bus_quiet_ev,
	output logic [3:0] core_irq,
	output logic [3:0] core_fiq,
	output logic ctrl_irq
);
	cmir_route_t route_q [`CMIR_NCORE];
	cmir_word_t rdata_q;
	cmir_nib_t stat_q;
	cmir_nib_t mask_q;
	cmir_nib_t fiq_prev_q;
	cmir_nib_t fiq_rise;
	logic [15:0] box_busy;
	logic [3:0] irq_w;
	logic [3:0] fiq_w;
	cmir_word_t cause_w [`CMIR_NCORE];
	logic wr_status;

	// ------------------------------------------------------------------------
	// Decoding shared by reads and writes
	// ------------------------------------------------------------------------
	function automatic logic in_bank(input logic [7:0] a, input logic [7:0] base);
		in_bank = ((a & `CMIR_BANK_MASK) == base) && ((a & `CMIR_WORD_MASK) == 8'h00);
	endfunction

	function automatic logic [1:0] core_of(input logic [7:0] a);
		core_of = a[`CMIR_CORE_SEL_LSB +: 2];
	endfunction

	// ------------------------------------------------------------------------
	// Mailbox readiness and core slices
	// ------------------------------------------------------------------------
	for (genvar m = 0; m < `CMIR_NBOX; m++)
	begin : g_box
		assign box_busy[m] = |box_data[m*`CMIR_BOX_W +: `CMIR_BOX_W];
	end

	for (genvar c = 0; c < `CMIR_NCORE; c++)
	begin : g_core
		cmir_core_if cif();
		assign cif.route = route_q[c];
		assign cif.box_busy = box_busy[4*c +: 4];
		assign cif.timer_ev = generic_timer_ev[4*c +: 4];
		assign cif.shared_ev_timer = local_timer_ev[c];
		assign cif.shared_ev_perf = perf_ev[c];
		assign cif.shared_ev_gpu = gpu_ev;
		assign cif.shared_ev_buserr = bus_error_ev;
		assign cif.shared_ev_quiet = bus_quiet_ev;
		cmir_slice #(.HAS_QUIET(c == 0)) u_slice
		(
			.sys_clk(sys_clk),
			.rstn(rstn),
			.cif(cif)
		);
		assign irq_w[c] = cif.irq;
		assign fiq_w[c] = cif.fiq;
		assign cause_w[c] = cif.cause;
	end

	assign core_irq = irq_w;
	assign core_fiq = fiq_w;

	// ------------------------------------------------------------------------
	// Routing registers
	// ------------------------------------------------------------------------
	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
		begin
			for (int c = 0; c < `CMIR_NCORE; c++)
				route_q[c] <= `CMIR_ROUTE_RST;
		end
		else if (reg_wr && in_bank(reg_addr, `CMIR_ROUTE_BASE))
			route_q[core_of(reg_addr)] <= reg_wdata[7:0];
	end

	// ------------------------------------------------------------------------
	// Control interrupt: one sticky bit per core on a new fast request
	// ------------------------------------------------------------------------
	assign fiq_rise = fiq_w & ~fiq_prev_q;
	assign wr_status = reg_wr && (reg_addr == `CMIR_STATUS_ADDR);

	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
			fiq_prev_q <= `CMIR_STAT_RST;
		else
			fiq_prev_q <= fiq_w;
	end

	// A rise in the clearing cycle survives the clear
	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
			stat_q <= `CMIR_STAT_RST;
		else
			stat_q <= (stat_q & ~(wr_status ? reg_wdata[3:0] : 4'h0)) | fiq_rise;
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
			mask_q <= `CMIR_STAT_RST;
		else if (reg_wr && (reg_addr == `CMIR_MASK_ADDR))
			mask_q <= reg_wdata[3:0];
	end

	assign ctrl_irq = |(stat_q & mask_q);

	// ------------------------------------------------------------------------
	// Read port: data valid the cycle after the strobe only
	// ------------------------------------------------------------------------
	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
			rdata_q <= 32'h0000_0000;
		else if (!reg_rd)
			rdata_q <= 32'h0000_0000;
		else if (in_bank(reg_addr, `CMIR_ROUTE_BASE))
			rdata_q <= {24'h00_0000, route_q[core_of(reg_addr)]};
		else if (in_bank(reg_addr, `CMIR_CAUSE_BASE))
			rdata_q <= cause_w[core_of(reg_addr)];
		else if (reg_addr == `CMIR_STATUS_ADDR)
			rdata_q <= {28'h000_0000, stat_q};
		else if (reg_addr == `CMIR_MASK_ADDR)
			rdata_q <= {28'h000_0000, mask_q};
		else
			rdata_q <= 32'h0000_0000;
	end

	assign reg_rdata = rdata_q;

	chk_route_reset: assert property (@(posedge sys_clk)
		!rstn |=> route_q[0] == 8'h00 && !core_fiq[0] [*2])
		else $error("routing not cleared by reset");
	chk_write_low_byte: assert property (@(posedge sys_clk) disable iff (!rstn)
		reg_wr && reg_addr == 8'h00 |=> route_q[0] == $past(reg_wdata[7:0]))
		else $error("route write not taken");
	chk_box_group: assert property (@(posedge sys_clk) disable iff (!rstn)
		route_q[1] == 8'h01 && box_busy[4] && !reg_wr [*2] |-> ##1 cause_w[1][4])
		else $error("core one mailbox four not shown");
	chk_sticky_clear: assert property (@(posedge sys_clk) disable iff (!rstn)
		fiq_rise[0] |=> stat_q[0])
		else $error("fast rise lost");
	cov_irq: cover property (@(posedge sys_clk) disable iff (!rstn) |core_irq);
	cov_ctrl: cover property (@(posedge sys_clk) disable iff (!rstn) ctrl_irq);
	cov_read: cover property (@(posedge sys_clk) disable iff (!rstn) reg_rd ##1 reg_rdata != 0);
endmodule
`default_nettype wire

/* File: tb/cmir_core_model.sv */
// Model of the four cores that receive the routed requests
`timescale 1ns/100ps
`default_nettype none
module cmir_core_model
(
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic [3:0] core_irq,
	input wire logic [3:0] core_fiq,
	output logic [7:0] fiq_rises,
	output logic both_seen
);
	logic [3:0] fiq_q;
	// Cores only watch; a real core cannot push back on a request line
	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
		begin
			fiq_q <= 4'h0;
			fiq_rises <= 8'h00;
			both_seen <= 1'b0;
		end
		else
		begin
			fiq_q <= core_fiq;
			fiq_rises <= fiq_rises + 8'($countones(core_fiq & ~fiq_q));
			if (|(core_irq & core_fiq))
				both_seen <= 1'b1;
		end
	end
endmodule
`default_nettype wire

/* File: tb/cmir_top_tb.sv */
// Self-checking testbench of the core mailbox interrupt router
`timescale 1ns/100ps
`default_nettype none
module cmir_top_tb;
	logic sys_clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0, reg_rdata;
	logic [511:0] box_data = '0, bd;
	logic [15:0] generic_timer_ev = 16'h0;
	logic [3:0] local_timer_ev = 4'h0, perf_ev = 4'h0, core_irq, core_fiq;
	logic gpu_ev = 1'b0, bus_error_ev = 1'b0, bus_quiet_ev = 1'b0, ctrl_irq, both_seen;
	logic [7:0] fiq_rises;
	logic [15:0] gt_tab [2] = '{16'hA53C, 16'h5AC3};
	logic [3:0] lt_tab [2] = '{4'h5, 4'hA};
	logic [3:0] pf_tab [2] = '{4'h3, 4'hC};
	logic g;
	int fail_count = 0, checks = 0, c, k, m, p;
	always #2.5 sys_clk = ~sys_clk;
	cmir_top i_dut (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .box_data(box_data),
		.generic_timer_ev(generic_timer_ev), .local_timer_ev(local_timer_ev), .perf_ev(perf_ev),
		.gpu_ev(gpu_ev), .bus_error_ev(bus_error_ev), .bus_quiet_ev(bus_quiet_ev),
		.core_irq(core_irq), .core_fiq(core_fiq), .ctrl_irq(ctrl_irq));
	cmir_core_model i_cores (.sys_clk(sys_clk), .rstn(rstn), .core_irq(core_irq),
		.core_fiq(core_fiq), .fiq_rises(fiq_rises), .both_seen(both_seen));
	// ------------------------------------------------------------------
	// Access tasks
	// ------------------------------------------------------------------
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe, so sample just past that edge
	task rd_chk(input logic [7:0] a, input logic [31:0] e);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, e);
	endtask
	// One mailbox filled at a time; an index of 16 empties them all
	task setbox(input int mb);
		bd = '0;
		if (mb < 16)
			bd[32*mb +: 32] = 32'h8000_0000 >> mb;
		@(posedge sys_clk);
		box_data <= bd;
		repeat (2) @(posedge sys_clk);
		#1;
	endtask
	task conclude;
		$display("checks=%0d fail_count=%0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// ------------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------------
	initial
	begin
		repeat (3) @(posedge sys_clk);
		rstn <= 1'b1;
		for (c = 0; c < 4; c++)
		begin
			rd_chk(8'(4*c), 32'h0);
			rd_chk(8'(16+4*c), 32'h0);
		end
		chk({24'h0, core_irq, core_fiq}, 32'h0);
		$display("test reset done");
		wr(8'h04, 32'hFFFF_FFFF);
		rd_chk(8'h04, 32'h0000_00FF);
		wr(8'h04, 32'h0);
		wr(8'h14, 32'hFFFF_FFFF);
		rd_chk(8'h14, 32'h0);
		rd_chk(8'h30, 32'h0);
		rd_chk(8'h05, 32'h0);
		$display("test access done");
		for (c = 0; c < 4; c++)
			for (k = 0; k < 4; k++)
			begin
				m = 4*c + k;
				wr(8'(4*c), 32'h1 << k);
				setbox((m + 4) % 16);
				chk({28'h0, core_irq}, 32'h0);
				setbox(m);
				chk({24'h0, core_irq, core_fiq}, {24'h0, 4'(1 << c), 4'h0});
				rd_chk(8'(16+4*c), 32'h10 << k);
				wr(8'(4*c), 32'h11 << k);
				repeat (2) @(posedge sys_clk);
				#1 chk({24'h0, core_irq, core_fiq}, {24'h0, 4'h0, 4'(1 << c)});
				rd_chk(8'(16+4*c), 32'h0);
				setbox(16);
				wr(8'(4*c), 32'h0);
			end
		$display("test mailbox done");
		rd_chk(8'h20, 32'hF);
		chk({31'h0, ctrl_irq}, 32'h0);
		wr(8'h24, 32'h1);
		#1 chk({31'h0, ctrl_irq}, 32'h1);
		wr(8'h20, 32'h1);
		#1 chk({31'h0, ctrl_irq}, 32'h0);
		rd_chk(8'h20, 32'hE);
		wr(8'h24, 32'hE);
		#1 chk({31'h0, ctrl_irq}, 32'h1);
		wr(8'h20, 32'hE);
		#1 chk({31'h0, ctrl_irq}, 32'h0);
		chk({24'h0, fiq_rises}, 32'h10);
		chk({31'h0, both_seen}, 32'h0);
		$display("test interrupt done");
		for (p = 0; p < 2; p++)
		begin
			g = (p == 0);
			@(posedge sys_clk);
			generic_timer_ev <= gt_tab[p];
			local_timer_ev <= lt_tab[p];
			perf_ev <= pf_tab[p];
			gpu_ev <= g;
			bus_error_ev <= g;
			bus_quiet_ev <= g;
			repeat (2) @(posedge sys_clk);
			for (c = 0; c < 4; c++)
				rd_chk(8'(16+4*c), {1'b0, g, 18'h0, lt_tab[p][c], g & (c == 0), pf_tab[p][c], g,
					4'h0, gt_tab[p][4*c +: 4]});
			chk({28'h0, core_irq}, 32'hF);
		end
		$display("test causes done");
		// Reset again with events and a fast mailbox live, so the reset branches matter
		wr(8'h08, 32'h0000_00F0);
		setbox(8);
		chk({28'h0, core_fiq}, 32'h0000_0004);
		@(posedge sys_clk);
		rstn <= 1'b0;
		@(posedge sys_clk);
		#1 chk({24'h0, core_irq, core_fiq}, 32'h0);
		@(posedge sys_clk);
		rstn <= 1'b1;
		rd_chk(8'h08, 32'h0);
		chk({28'h0, core_fiq}, 32'h0);
		rd_chk(8'h18, 32'h0000_020A);
		$display("test mid reset done");
		conclude();
	end
	initial
	begin
		repeat (5000) @(posedge sys_clk);
		fail_count++;
		conclude();
	end
endmodule
`default_nettype wire
